// ===== design/dtd_timer_top.v
// dual 8-bit and 16-bit counter/timer with transmit, demodulation and
// alternating modes; registers reached through a simple bank port
// assumes a write strobe from the same clock and asynchronous input pins
//
// Functional notes
// - control bit 7 selects transmit or demodulation
// - bit 6 routes line six or input pin
// - bits 5:4 pick AND OR NOR NAND
// - bits 5:4 select falling, rising or both edges
// - pulses under programmed width are filtered out
// - idle short timer output is inverted bit 1
// - negative edge to high, positive to low capture
// - capture sets edge status, optional interrupt
// - short timer reloads all ones after capture
// - in demodulation, zero sets timeout, interrupt, reload all ones
// - alternating mode hands enables between timers
// - each timer sets timeout at terminal count
// - aux register low five bits read ones
// - capture interrupt enable gates capture interrupt
// - counter interrupt enable gates timeout interrupt
// - select bit puts short timer on line four
// - long timer source three, short source four
// - combine bits survive stop recovery, reset zero
`timescale 1ns/1ps
`include "dtd_consts.vh"

module dtd_timer_top #(
  parameter FCW = 5
) (
  input wire clk,
  input wire rst_n,
  input wire stop_recovery,
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire port_three_line_one,
  input wire port_two_line_zero,
  input wire line4_latch,
  input wire line6_latch,
  output reg port_three_line_four,
  output reg port_three_line_six,
  output reg interrupt_source_three,
  output reg interrupt_source_four
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0] t8c_q, t8c_d, shc_q, shc_d, t16c_q, t16c_d;
  reg [2:0] auxc_q, auxc_d;
  reg [7:0] t8lc_q, t8hc_q, t16lc_q, t16hc_q;
  reg [7:0] c16l_q, c16h_q, c8l_q, c8h_q;
  reg [7:0] cnt8_q;
  reg [15:0] cnt16_q;
  reg short_timer_output_q, t16_out_q, t8_en_q, t16_en_q;
  reg comb;
  reg [FCW-1:0] min_width;
  wire pos_pulse, neg_pulse;

  wire demod = shc_q[`DTD_B_MODE];
  wire [1:0] fn = shc_q[`DTD_B_FN_HI:`DTD_B_FN_LO];
  wire t8_en = t8c_q[`DTD_B_EN];
  wire t16_en = t16c_q[`DTD_B_EN];
  wire alt = auxc_q[`DTD_B_ALT-5] & ~demod;
  wire wr_t8c = reg_wr && (reg_addr == `DTD_A_T8CTL);
  wire wr_shc = reg_wr && (reg_addr == `DTD_A_SHCTL);
  wire wr_t16c = reg_wr && (reg_addr == `DTD_A_T16CTL);
  wire wr_aux = reg_wr && (reg_addr == `DTD_A_AUXCTL);
  wire t8_zero = t8_en && t8_en_q && (cnt8_q == `DTD_ZERO8);
  wire t16_zero = t16_en && t16_en_q && (cnt16_q == `DTD_ZERO16);
  wire take_neg = demod && neg_pulse && (fn == `DTD_ED_FALL || fn == `DTD_ED_BOTH);
  wire take_pos = demod && pos_pulse && (fn == `DTD_ED_RISE || fn == `DTD_ED_BOTH);
  wire cap8 = (take_neg | take_pos) && t8_en;
  wire cap16 = (take_neg | take_pos) && t16_en;

  // ----------------------------------------------------------------
  // input circuit
  // ----------------------------------------------------------------
  // filter width select
  always @* begin
    case (shc_q[`DTD_B_FW_HI:`DTD_B_FW_LO])
      2'h0: min_width = `DTD_FW0;
      2'h1: min_width = `DTD_FW1;
      2'h2: min_width = `DTD_FW2;
      default: min_width = `DTD_FW3;
    endcase
  end

  dtd_edge_filt #(
    .CW(FCW)
  ) u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .pin_a(port_three_line_one),
    .pin_b(port_two_line_zero),
    .sel_b(shc_q[`DTD_B_SEL6]),
    .min_width(min_width),
    .pos_pulse(pos_pulse),
    .neg_pulse(neg_pulse)
  );

  // ----------------------------------------------------------------
  // control register next values; hardware sets win over clears
  // ----------------------------------------------------------------
  always @* begin
    t8c_d = t8c_q;
    if (wr_t8c) begin
      t8c_d = reg_wdata;
      t8c_d[`DTD_B_TOUT] = t8c_q[`DTD_B_TOUT] & ~reg_wdata[`DTD_B_TOUT];
    end
    if (t8_zero)
      t8c_d[`DTD_B_TOUT] = 1'b1;
    if (alt && t8_zero) begin
      t8c_d[`DTD_B_EN] = 1'b0;
    end else if (alt && t16_zero) begin
      t8c_d[`DTD_B_EN] = 1'b1;
    end
  end

  always @* begin
    t16c_d = t16c_q;
    if (wr_t16c) begin
      t16c_d = reg_wdata;
      t16c_d[`DTD_B_TOUT] = t16c_q[`DTD_B_TOUT] & ~reg_wdata[`DTD_B_TOUT];
    end
    if (t16_zero)
      t16c_d[`DTD_B_TOUT] = 1'b1;
    if (alt && t16_zero) begin
      t16c_d[`DTD_B_EN] = 1'b0;
    end else if (alt && t8_zero) begin
      t16c_d[`DTD_B_EN] = 1'b1;
    end
  end

  always @* begin
    shc_d = shc_q;
    if (wr_shc) begin
      shc_d[7:2] = reg_wdata[7:2];
      if (demod) begin
        shc_d[1:0] = shc_q[1:0] & ~reg_wdata[1:0];
      end else begin
        shc_d[1:0] = reg_wdata[1:0];
      end
    end
    if (cap8 && take_neg)
      shc_d[`DTD_B_ST_NEG] = 1'b1;
    if (cap8 && take_pos)
      shc_d[`DTD_B_ST_POS] = 1'b1;
  end

  always @* begin
    auxc_d = auxc_q;
    if (wr_aux)
      auxc_d = reg_wdata[7:5];
  end

  // ----------------------------------------------------------------
  // output combination
  // ----------------------------------------------------------------
  // logic function
  always @* begin
    case (fn)
      `DTD_FN_AND: comb = short_timer_output_q & t16_out_q;
      `DTD_FN_OR: comb = short_timer_output_q | t16_out_q;
      `DTD_FN_NOR: comb = ~(short_timer_output_q | t16_out_q);
      default: comb = ~(short_timer_output_q & t16_out_q);
    endcase
  end

  // ----------------------------------------------------------------
  // registers and counters
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      t8c_q <= `DTD_RST8;
      shc_q <= `DTD_RST8;
      t16c_q <= `DTD_RST8;
      auxc_q <= 3'h0;
      t8lc_q <= `DTD_RST8;
      t8hc_q <= `DTD_RST8;
      t16lc_q <= `DTD_RST8;
      t16hc_q <= `DTD_RST8;
      c16l_q <= `DTD_RST8;
      c16h_q <= `DTD_RST8;
      c8l_q <= `DTD_RST8;
      c8h_q <= `DTD_RST8;
      cnt8_q <= `DTD_RST8;
      cnt16_q <= `DTD_RST16;
      short_timer_output_q <= 1'b1;
      t16_out_q <= 1'b0;
      t8_en_q <= 1'b0;
      t16_en_q <= 1'b0;
    end else if (stop_recovery) begin
      t8c_q <= `DTD_RST8;
      shc_q <= {2'h0, shc_q[`DTD_B_FN_HI:`DTD_B_FN_LO], 4'h0};
      t16c_q <= `DTD_RST8;
      auxc_q <= 3'h0;
      cnt8_q <= `DTD_RST8;
      cnt16_q <= `DTD_RST16;
      short_timer_output_q <= 1'b1;
      t16_out_q <= 1'b0;
      t8_en_q <= 1'b0;
      t16_en_q <= 1'b0;
    end else begin
      t8c_q <= t8c_d;
      shc_q <= shc_d;
      t16c_q <= t16c_d;
      auxc_q <= auxc_d;
      t8_en_q <= t8_en;
      t16_en_q <= t16_en;
      if (reg_wr && reg_addr == `DTD_A_T8LC)
        t8lc_q <= reg_wdata;
      if (reg_wr && reg_addr == `DTD_A_T8HC)
        t8hc_q <= reg_wdata;
      if (reg_wr && reg_addr == `DTD_A_T16LC)
        t16lc_q <= reg_wdata;
      if (reg_wr && reg_addr == `DTD_A_T16HC)
        t16hc_q <= reg_wdata;

      // short timer
      if (!t8_en) begin
        short_timer_output_q <= ~shc_q[`DTD_B_ST_NEG];
      end else if (!t8_en_q) begin
        cnt8_q <= demod ? `DTD_RELOAD8 : (short_timer_output_q ? t8hc_q : t8lc_q);
      end else if (demod) begin
        if (cap8) begin
          if (take_neg)
            c8h_q <= cnt8_q;
          if (take_pos)
            c8l_q <= cnt8_q;
          cnt8_q <= `DTD_RELOAD8;
        end else if (t8_zero) begin
          cnt8_q <= `DTD_RELOAD8;
        end else begin
          cnt8_q <= cnt8_q - 8'h01;
        end
      end else if (t8_zero) begin
        short_timer_output_q <= ~short_timer_output_q;
        cnt8_q <= short_timer_output_q ? t8lc_q : t8hc_q;
      end else begin
        cnt8_q <= cnt8_q - 8'h01;
      end

      // long timer
      if (!t16_en) begin
        t16_out_q <= 1'b0;
      end else if (!t16_en_q) begin
        cnt16_q <= demod ? `DTD_RELOAD16 : {t16hc_q, t16lc_q};
      end else if (demod) begin
        if (cap16) begin
          {c16h_q, c16l_q} <= cnt16_q;
          cnt16_q <= `DTD_RELOAD16;
        end else if (t16_zero) begin
          cnt16_q <= `DTD_RELOAD16;
        end else begin
          cnt16_q <= cnt16_q - 16'h0001;
        end
      end else if (t16_zero) begin
        t16_out_q <= ~t16_out_q;
        cnt16_q <= {t16hc_q, t16lc_q};
      end else begin
        cnt16_q <= cnt16_q - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins, interrupts and read data
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      port_three_line_four <= 1'b0;
      port_three_line_six <= 1'b0;
      interrupt_source_three <= 1'b0;
      interrupt_source_four <= 1'b0;
      reg_rdata <= `DTD_RST8;
    end else begin
      port_three_line_four <= t8c_q[`DTD_B_P34] ? short_timer_output_q : line4_latch;
      port_three_line_six <= (!demod && shc_q[`DTD_B_SEL6]) ? comb : line6_latch;
      interrupt_source_three <= t16_zero && t16c_q[`DTD_B_CNTIE];
      interrupt_source_four <= (t8_zero && t8c_q[`DTD_B_CNTIE]) ||
                               (cap8 && t8c_q[`DTD_B_CAPIE]);
      case (reg_addr)
        `DTD_A_T8CTL: reg_rdata <= t8c_q;
        `DTD_A_SHCTL: reg_rdata <= shc_q;
        `DTD_A_T16CTL: reg_rdata <= t16c_q;
        `DTD_A_AUXCTL: reg_rdata <= {auxc_q, `DTD_AUX_RSVD};
        `DTD_A_T8LC: reg_rdata <= t8lc_q;
        `DTD_A_T8HC: reg_rdata <= t8hc_q;
        `DTD_A_T16LC: reg_rdata <= t16lc_q;
        `DTD_A_T16HC: reg_rdata <= t16hc_q;
        `DTD_A_C16L: reg_rdata <= c16l_q;
        `DTD_A_C16H: reg_rdata <= c16h_q;
        `DTD_A_C8L: reg_rdata <= c8l_q;
        `DTD_A_C8H: reg_rdata <= c8h_q;
        default: reg_rdata <= `DTD_RST8;
      endcase
    end
  end

endmodule // dtd_timer_top

// ===== pkg/dtd_consts.vh
// constants for the dual timer with transmit and demodulation modes
// assumes inclusion by bare name from the design files
`ifndef DTD_CONSTS_VH
`define DTD_CONSTS_VH

// ----------------------------------------------------------------
// register addresses in the expanded bank
// ----------------------------------------------------------------
`define DTD_A_T8CTL 4'h0
`define DTD_A_SHCTL 4'h1
`define DTD_A_T16CTL 4'h2
`define DTD_A_AUXCTL 4'h3
`define DTD_A_T8LC 4'h4
`define DTD_A_T8HC 4'h5
`define DTD_A_T16LC 4'h6
`define DTD_A_T16HC 4'h7
`define DTD_A_C16L 4'h8
`define DTD_A_C16H 4'h9
`define DTD_A_C8L 4'hA
`define DTD_A_C8H 4'hB

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DTD_B_EN 7
`define DTD_B_TOUT 5
`define DTD_B_CAPIE 2
`define DTD_B_CNTIE 1
`define DTD_B_P34 0
`define DTD_B_MODE 7
`define DTD_B_SEL6 6
`define DTD_B_FN_HI 5
`define DTD_B_FN_LO 4
`define DTD_B_FW_HI 3
`define DTD_B_FW_LO 2
`define DTD_B_ST_NEG 1
`define DTD_B_ST_POS 0
`define DTD_B_ALT 6

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define DTD_RST8 8'h00
`define DTD_RST16 16'h0000
`define DTD_AUX_RSVD 5'h1F
`define DTD_RELOAD8 8'hFF
`define DTD_RELOAD16 16'hFFFF
`define DTD_ZERO8 8'h00
`define DTD_ZERO16 16'h0000
`define DTD_FN_AND 2'h0
`define DTD_FN_OR 2'h1
`define DTD_FN_NOR 2'h2
`define DTD_FN_NAND 2'h3
`define DTD_ED_FALL 2'h0
`define DTD_ED_RISE 2'h1
`define DTD_ED_BOTH 2'h2
`define DTD_FW0 5'h01
`define DTD_FW1 5'h04
`define DTD_FW2 5'h08
`define DTD_FW3 5'h10

`endif

// ===== design/dtd_edge_filt.v
// synchroniser, glitch filter and edge detector for the demodulator input
// assumes two asynchronous pins and a selector from the same clock domain
`timescale 1ns/1ps
`include "dtd_consts.vh"

module dtd_edge_filt #(
  parameter CW = 5
) (
  input wire clk,
  input wire rst_n,
  input wire pin_a,
  input wire pin_b,
  input wire sel_b,
  input wire [CW-1:0] min_width,
  output reg pos_pulse,
  output reg neg_pulse
);

  // ----------------------------------------------------------------
  // two-stage synchronisers, selection after the second stage
  // ----------------------------------------------------------------
  reg a1_q, a2_q, b1_q, b2_q;
  reg filt_q;
  reg [CW-1:0] run_q;
  wire in_s;
  wire [CW-1:0] run_inc;

  assign in_s = sel_b ? b2_q : a2_q;
  assign run_inc = run_q + {{(CW-1){1'b0}}, 1'b1};

  // pins idle high; resetting to that level avoids a false edge after reset
  always @(posedge clk) begin
    if (!rst_n) begin
      a1_q <= 1'b1;
      a2_q <= 1'b1;
      b1_q <= 1'b1;
      b2_q <= 1'b1;
    end else begin
      a1_q <= pin_a;
      a2_q <= a1_q;
      b1_q <= pin_b;
      b2_q <= b1_q;
    end
  end

  // ----------------------------------------------------------------
  // filter: a new level must hold min_width cycles to be accepted
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      filt_q <= 1'b1;
      run_q <= {CW{1'b0}};
      pos_pulse <= 1'b0;
      neg_pulse <= 1'b0;
    end else begin
      pos_pulse <= 1'b0;
      neg_pulse <= 1'b0;
      if (in_s == filt_q) begin
        run_q <= {CW{1'b0}};
      end else if (run_inc >= min_width) begin
        filt_q <= in_s;
        run_q <= {CW{1'b0}};
        pos_pulse <= in_s;
        neg_pulse <= ~in_s;
      end else begin
        run_q <= run_inc;
      end
    end
  end

endmodule // dtd_edge_filt

// ===== sim/dtd_timer_monitor.sv
// checker for the dual timer: register port, pin routing, interrupt gating
// assumes binding to dtd_timer_top, one clock, synchronous active-low reset
`timescale 1ns/1ps
module dtd_timer_monitor (
  input wire clk,
  input wire rst_n,
  input wire stop_recovery,
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire line4_latch,
  input wire line6_latch,
  input wire port_three_line_four,
  input wire port_three_line_six,
  input wire interrupt_source_three,
  input wire interrupt_source_four
);
  // shadow of the software-only control bits, cleared like the design
  reg [2:0] t8_q;
  reg [1:0] sh_q;
  reg ie3_q;
  wire ie4 = |t8_q[2:1];
  always @(posedge clk) begin
    if (!rst_n || stop_recovery) begin
      t8_q <= 3'h0;
      sh_q <= 2'h0;
      ie3_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 4'h0) t8_q <= reg_wdata[2:0];
      if (reg_addr == 4'h1) sh_q <= reg_wdata[7:6];
      if (reg_addr == 4'h2) ie3_q <= reg_wdata[1];
    end
  end

  a_reset_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> reg_rdata == 8'h00 && !interrupt_source_three
      && !interrupt_source_four && !port_three_line_six)
    else $error("outputs not clear after reset");
  a_aux_ones: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(reg_addr) == 4'h3 |-> reg_rdata[4:0] == 5'h1F)
    else $error("aux low bits not ones");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(reg_addr) >= 4'hC |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_const_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == 4'h5 ##1 !reg_wr && reg_addr == 4'h5)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("constant readback wrong");
  a_line6_latch: assert property (@(posedge clk) disable iff (!rst_n)
    sh_q != 2'b01 && !stop_recovery |=> port_three_line_six == $past(line6_latch))
    else $error("line six not following latch");
  a_line4_latch: assert property (@(posedge clk) disable iff (!rst_n)
    !t8_q[0] && !stop_recovery |=> port_three_line_four == $past(line4_latch))
    else $error("line four not following latch");
  a_interrupt_source_four_gate: assert property (@(posedge clk) disable iff (!rst_n)
    interrupt_source_four |-> $past(ie4) || $past(ie4, 2))
    else $error("short timer request while masked");
  a_interrupt_source_three_gate: assert property (@(posedge clk) disable iff (!rst_n)
    interrupt_source_three |-> $past(ie3_q) || $past(ie3_q, 2))
    else $error("long timer request while masked");
endmodule // dtd_timer_monitor

// ===== sim/dtd_pin_model.sv
// model of the external pulse-coded signal on the two demodulator pins
// assumes the bench calls pulse from its own process; idle level is high
`timescale 1ns/1ps
module dtd_pin_model (
  input wire clk,
  output reg pin_a,
  output reg pin_b
);
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b1;
  end
  // low pulse of w clocks on the chosen pin, launched off the rising edge
  task pulse(input sel, input [7:0] w);
    begin
      @(posedge clk);
      if (sel) pin_b <= 1'b0;
      else pin_a <= 1'b0;
      repeat (w) @(posedge clk);
      pin_a <= 1'b1;
      pin_b <= 1'b1;
    end
  endtask
endmodule // dtd_pin_model

// ===== sim/dtd_timer_top_tb.sv
// self-checking bench for the dual timer block
// assumes the pin model and the checker, bound here, from the sim folder
`timescale 1ns/1ps
bind dtd_timer_top dtd_timer_monitor mon (.clk, .rst_n, .stop_recovery, .reg_addr,
  .reg_wr, .reg_wdata, .reg_rdata, .line4_latch, .line6_latch, .port_three_line_four,
  .port_three_line_six, .interrupt_source_three, .interrupt_source_four);
module dtd_timer_top_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg stop_recovery = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg reg_wr = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg line4_latch = 1'b0;
  reg line6_latch = 1'b0;
  wire [7:0] reg_rdata;
  wire port_three_line_one, port_two_line_zero;
  wire port_three_line_four, port_three_line_six;
  wire interrupt_source_three, interrupt_source_four;
  integer fails = 0;
  integer check_count = 0;
  integer n3 = 0;
  integer n4 = 0;
  integer i, k, j;
  reg [7:0] rd;
  reg [19:0] rrow [0:9];
  reg [27:0] drow [0:8];
  always #20 clk = ~clk;
  always @(posedge clk) begin
    line6_latch <= ~line6_latch;
    line4_latch <= line6_latch;
    // outputs are unknown until the first reset edge
    if (rst_n) begin
      n3 <= n3 + interrupt_source_three;
      n4 <= n4 + interrupt_source_four;
    end
  end
  dtd_pin_model pm (.clk, .pin_a(port_three_line_one), .pin_b(port_two_line_zero));
  dtd_timer_top #(.FCW(5)) uut (.clk, .rst_n, .stop_recovery, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .port_three_line_one, .port_two_line_zero, .line4_latch,
    .line6_latch, .port_three_line_four, .port_three_line_six,
    .interrupt_source_three, .interrupt_source_four);
  task chk(input [8*10-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rdr(input [3:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      #1 rd = reg_rdata;
    end
  endtask
  task rst;
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
    end
  endtask
  // combined output with the long timer idle at 0
  function comb(input [1:0] f, input t);
    comb = (f == 2'h0) ? 1'b0 : (f == 2'h1) ? t : (f == 2'h2) ? ~t : 1'b1;
  endfunction
  task finish_test;
    begin
      if (fails == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails = fails + 1;
    finish_test;
  end
  initial begin
    // rows: address, write data, expected readback
    rrow[0] = 20'h5AAAA; rrow[1] = 20'h45555; rrow[2] = 20'h7C3C3;
    rrow[3] = 20'h63C3C; rrow[4] = 20'h3001F; rrow[5] = 20'h3A0BF;
    rrow[6] = 20'h81200; rrow[7] = 20'hB3400; rrow[8] = 20'hCFF00;
    rrow[9] = 20'h13030;
    // rows: edge code, filter code, pin, width, status, request count
    drow[0] = 28'h0100C21; drow[1] = 28'h1100C11; drow[2] = 28'h2100C32;
    drow[3] = 28'h3100C00; drow[4] = 28'h2100300; drow[5] = 28'h2100432;
    drow[6] = 28'h2300C00; drow[7] = 28'h2311432; drow[8] = 28'h2010132;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i = i + 1) begin
      rdr(i[3:0]);
      chk("reset", (i == 3) ? 8'h1F : 8'h00, rd);
    end
    for (i = 0; i < 10; i = i + 1) begin
      wr(rrow[i][19:16], rrow[i][15:8]);
      rdr(rrow[i][19:16]);
      chk("regrow", rrow[i][7:0], rd);
    end
    wr(4'h0, 8'h01);
    for (i = 0; i < 8; i = i + 1) begin
      wr(4'h1, {2'b01, i[2:1], 2'b00, i[0], 1'b0});
      repeat (3) @(posedge clk);
      #1 chk("line6", {7'h0, comb(i[2:1], ~i[0])}, {7'h0, port_three_line_six});
      chk("line4", {7'h0, ~i[0]}, {7'h0, port_three_line_four});
    end
    for (i = 0; i < 9; i = i + 1) begin
      rst;
      wr(4'h1, {1'b1, drow[i][16], drow[i][25:24], drow[i][21:20], 2'b00});
      wr(4'h0, 8'h84);
      k = n4;
      pm.pulse(drow[i][16], drow[i][15:8]);
      repeat (30) @(posedge clk);
      rdr(4'h1);
      chk("edge_st", {6'h0, drow[i][5:4]}, {6'h0, rd[1:0]});
      chk("cap_irq", {6'h0, drow[i][1:0]}, 8'(n4 - k));
      if (drow[i][5:4] == 2'h3) begin
        rdr(4'hA);
        j = (rd >= 9'h0FD - drow[i][15:8]) && (rd <= 9'h101 - drow[i][15:8]);
        chk("cap_lo", 8'h01, 8'(j));
        rdr(4'hB);
        chk("cap_hi", 8'h01, {7'h0, rd != 8'h00});
        wr(4'h1, {1'b1, drow[i][16], drow[i][25:24], drow[i][21:20], 2'b11});
        rdr(4'h1);
        chk("st_clear", 8'h00, {6'h0, rd[1:0]});
      end
    end
    rst;
    wr(4'h1, 8'h80);
    wr(4'h0, 8'h82);
    k = n4;
    repeat (270) @(posedge clk);
    chk("tout_irq", 8'h01, 8'(n4 - k));
    rdr(4'h0);
    chk("tout_flag", 8'h20, rd & 8'h20);
    repeat (256) @(posedge clk);
    chk("tout_again", 8'h02, 8'(n4 - k));
    rst;
    wr(4'h4, 8'h03);
    wr(4'h5, 8'h03);
    wr(4'h6, 8'h05);
    wr(4'h7, 8'h00);
    wr(4'h3, 8'h40);
    wr(4'h2, 8'h02);
    k = n4;
    j = n3;
    wr(4'h0, 8'h82);
    repeat (100) @(posedge clk);
    chk("alt_t8", 8'h01, {7'h0, n4 > k});
    chk("alt_t16", 8'h01, {7'h0, n3 > j});
    rdr(4'h2);
    chk("alt_tout", 8'h20, rd & 8'h20);
    wr(4'h1, 8'h7C);
    @(posedge clk);
    stop_recovery <= 1'b1;
    @(posedge clk);
    stop_recovery <= 1'b0;
    rdr(4'h1);
    chk("smr_shared", 8'h30, rd);
    rdr(4'h6);
    chk("smr_const", 8'h05, rd);
    finish_test;
  end
endmodule // dtd_timer_top_tb
